// *** verilog/guard_pkg.sv ***
// Package: constants and carriers for the privilege flag guard
package guard_pkg;

	// ==========================================================
	// Flag word bit positions (bit 0 is the msb of a 36-bit word)
	localparam int FLAG_W       = 36;
	localparam int BIT_USER     = 5;
	localparam int BIT_USER_IO  = 6;
	localparam int BIT_PUBLIC   = 7;

	// ==========================================================
	// Device codes, jump functions and section limit
	localparam logic [8:0] DEV_USER_LIMIT = 9'h1E0;
	localparam logic [3:0] FN_ENTRY_GATE  = 4'h1;
	localparam logic [3:0] FN_HALT        = 4'h4;
	localparam logic [3:0] FN_RESTORE     = 4'h2;
	localparam logic [3:0] FN_DISMISS     = 4'hC;
	localparam logic [3:0] FN_INT_MASK    = 4'h8;
	localparam logic [11:0] SECT_AC_MAX   = 12'h001;

	// ==========================================================
	// APB register map
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_FLAGS  = 8'h04;
	localparam logic [7:0] ADDR_REQ    = 8'h08;
	localparam logic [7:0] ADDR_WORD   = 8'h0C;
	localparam logic [7:0] ADDR_RESULT = 8'h10;
	localparam logic [7:0] ADDR_STAT   = 8'h14;
	localparam logic [7:0] ADDR_SECT   = 8'h18;

	// Request kinds
	typedef enum logic [2:0] {
		REQ_NONE    = 3'b000,
		REQ_RESTORE = 3'b001,
		REQ_IO      = 3'b010,
		REQ_JUMP    = 3'b011,
		REQ_READ    = 3'b100,
		REQ_WRITE   = 3'b101,
		REQ_FETCH   = 3'b110,
		REQ_UNPAGED = 3'b111
	} req_e;

	// Processor mode flags
	typedef struct packed {
		logic user;
		logic user_io;
		logic public_m;
		logic supervisor;
	} mode_s;

	// Access request
	typedef struct packed {
		req_e        kind;
		logic [8:0]  dev;
		logic [3:0]  fn;
		logic        concealed;
		logic        wprot;
		logic        gate_word;
		logic        small_model;
		logic [11:0] section;
	} check_s;

endpackage

// *** verilog/guard_check.sv ***
// Module: combinational legality check of one request
`timescale 1ns/1ns
`default_nettype none
module guard_check (
	// Current mode and request
	input  wire guard_pkg::mode_s  mode,
	input  wire guard_pkg::check_s req,
	// Verdict
	output logic                   allow,
	output logic                   halt,
	output logic                   ac_ok
);
	logic io_legal;
	logic kernel;

	always_comb begin
		kernel = !mode.user && !mode.supervisor;
		io_legal = kernel || mode.user_io
			|| (!req.small_model && req.dev >= guard_pkg::DEV_USER_LIMIT);
		allow = 1'b1;
		halt  = 1'b0;
		ac_ok = req.section <= guard_pkg::SECT_AC_MAX;
		case (req.kind)
			guard_pkg::REQ_IO: begin
				allow = io_legal;
			end
			guard_pkg::REQ_JUMP: begin
				if (req.fn == guard_pkg::FN_HALT) begin
					allow = kernel;
					halt  = kernel;
				end else if (req.fn >= guard_pkg::FN_INT_MASK) begin
					allow = io_legal;
				end
			end
			guard_pkg::REQ_READ: begin
				allow = !req.concealed || !mode.public_m
					|| (!mode.user && mode.supervisor);
			end
			guard_pkg::REQ_WRITE: begin
				allow = (!req.concealed || !mode.public_m) && !req.wprot
					&& !(req.concealed && mode.supervisor);
			end
			guard_pkg::REQ_FETCH: begin
				allow = !req.concealed || !mode.public_m || req.gate_word;
			end
			guard_pkg::REQ_UNPAGED: begin
				allow = kernel;
			end
			default: begin
				allow = 1'b1;
			end
		endcase
	end

endmodule
`default_nettype wire

// *** verilog/privilege_flag_guard.sv ***
// Module: privilege flag guard with APB register access
// ==========================================================
`timescale 1ns/1ns
`default_nettype none
module privilege_flag_guard (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Status outputs
	output logic             halted,
	output logic             trap
);
	// ==========================================================
	// Registers and combinational signals
	guard_pkg::mode_s  mode_ff,  nxt_mode;
	guard_pkg::check_s req_ff,   nxt_req;
	logic [35:0]       word_ff,  nxt_word;
	logic              halt_ff,  nxt_halt;
	logic              trap_ff,  nxt_trap;
	logic              ok_ff,    nxt_ok;
	logic              ac_ff,    nxt_ac;
	logic              go;
	logic              allow;
	logic              halt_req;
	logic              ac_ok;
	logic [31:0]       rd;
	logic              mapped;

	guard_check u_check (
		.mode  (mode_ff),
		.req   (req_ff),
		.allow (allow),
		.halt  (halt_req),
		.ac_ok (ac_ok)
	);

	// ==========================================================
	// Bus decode
	assign pready  = 1'b1;
	assign go      = psel && penable && pwrite && paddr == guard_pkg::ADDR_REQ;
	always_comb begin
		mapped = 1'b1;
		rd     = 32'h0000_0000;
		case (paddr)
			guard_pkg::ADDR_CTRL:  rd = {28'h000_0000, mode_ff};
			guard_pkg::ADDR_FLAGS: begin
				// bit 6 (from msb of 36) is word bit 29
				rd = 32'h0000_0000;
				rd[guard_pkg::FLAG_W-1-guard_pkg::BIT_USER] = mode_ff.user;
				rd[guard_pkg::FLAG_W-1-guard_pkg::BIT_USER_IO] = mode_ff.user_io;
				rd[guard_pkg::FLAG_W-1-guard_pkg::BIT_PUBLIC] = mode_ff.public_m;
			end
			guard_pkg::ADDR_REQ:    rd = req_ff;
			guard_pkg::ADDR_WORD:   rd = word_ff[31:0];
			guard_pkg::ADDR_RESULT: rd = {28'h000_0000, ac_ff, ok_ff, trap_ff, halt_ff};
			guard_pkg::ADDR_STAT:   rd = {31'h0000_0000, allow};
			guard_pkg::ADDR_SECT:   rd = {20'h0_0000, req_ff.section};
			default:                mapped = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd;
		end
	end

	// ==========================================================
	// Mode, request and verdict
	always_comb begin
		nxt_mode = mode_ff;
		nxt_req  = req_ff;
		nxt_word = word_ff;
		nxt_halt = halt_ff;
		nxt_trap = trap_ff;
		nxt_ok   = ok_ff;
		nxt_ac   = ac_ff;
		if (psel && penable && pwrite) begin
			case (paddr)
				guard_pkg::ADDR_CTRL: begin
					if (!mode_ff.user) begin
						nxt_mode = guard_pkg::mode_s'(pwdata[3:0]);
					end
					nxt_halt = pwdata[4] ? 1'b0 : halt_ff;
					nxt_trap = pwdata[5] ? 1'b0 : trap_ff;
				end
				guard_pkg::ADDR_WORD: begin
					nxt_word = {4'h0, pwdata};
				end
				guard_pkg::ADDR_REQ: begin
					nxt_req = guard_pkg::check_s'(pwdata);
				end
				default: begin
					nxt_word = word_ff;
				end
			endcase
		end
		if (ok_ff == 1'b0 && go == 1'b0 && req_ff.kind != guard_pkg::REQ_NONE) begin
			nxt_ok = 1'b1;
			nxt_ac = ac_ok;
			nxt_req.kind = guard_pkg::REQ_NONE;
			if (!allow) begin
				nxt_trap = 1'b1;
			end else if (halt_req) begin
				nxt_halt = 1'b1;
			end else if (req_ff.kind == guard_pkg::REQ_RESTORE) begin
				if (mode_ff.user) begin
					nxt_mode.user = 1'b1;
					nxt_mode.user_io = mode_ff.user_io
						& word_ff[guard_pkg::FLAG_W-1-guard_pkg::BIT_USER_IO];
				end else begin
					nxt_mode.user = word_ff[guard_pkg::FLAG_W-1-guard_pkg::BIT_USER];
					nxt_mode.user_io = word_ff[guard_pkg::FLAG_W-1-guard_pkg::BIT_USER_IO];
				end
				if (word_ff[guard_pkg::FLAG_W-1-guard_pkg::BIT_PUBLIC]) begin
					nxt_mode.public_m = 1'b1;
				end
			end
		end
		if (go) begin
			nxt_ok = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_ff <= '0;
			req_ff  <= '0;
			word_ff <= 36'h0_0000_0000;
			halt_ff <= 1'b0;
			trap_ff <= 1'b0;
			ok_ff   <= 1'b1;
			ac_ff   <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			req_ff  <= nxt_req;
			word_ff <= nxt_word;
			halt_ff <= nxt_halt;
			trap_ff <= nxt_trap;
			ok_ff   <= nxt_ok;
			ac_ff   <= nxt_ac;
		end
	end

	assign halted = halt_ff;
	assign trap   = trap_ff;

endmodule
`default_nettype wire

// *** verif/privilege_flag_guard_props.sv ***
// Checker: port-level properties of the privilege flag guard
`timescale 1ns/1ns
`default_nettype none
module privilege_flag_guard_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// Status
	input wire logic        halted,
	input wire logic        trap
);
	// ==========================================================
	// Decoded transfers
	logic acc, map_ok, req_wr, hlt_wr, clr_h, clr_t;
	assign acc    = psel && penable && pready && pwrite;
	assign map_ok = paddr <= 8'h18 && paddr[1:0] == 2'h0;
	assign req_wr = acc && paddr == guard_pkg::ADDR_REQ;
	assign hlt_wr = req_wr && pwdata[31:29] == 3'h3
		&& pwdata[19:16] == guard_pkg::FN_HALT;
	assign clr_h  = acc && paddr == guard_pkg::ADDR_CTRL && pwdata[4];
	assign clr_t  = acc && paddr == guard_pkg::ADDR_CTRL && pwdata[5];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Properties
	sequence s_verdict;
		##[1:2] (halted || trap);
	endsequence
	property p_reset;
		disable iff (1'b0) !rst_n |=> !halted && !trap;
	endproperty
	property p_ready;
		pready;
	endproperty
	property p_err;
		pslverr == (psel && penable && !map_ok);
	endproperty
	property p_halt;
		hlt_wr |-> s_verdict;
	endproperty
	property p_halt_src;
		$rose(halted) |-> $past(hlt_wr) || $past(hlt_wr, 2);
	endproperty
	property p_trap_src;
		$rose(trap) |-> $past(req_wr) || $past(req_wr, 2);
	endproperty
	property p_trap_hold;
		trap && !clr_t |=> trap;
	endproperty
	property p_halt_hold;
		halted && !clr_h |=> halted;
	endproperty
	property p_trap_clr;
		clr_t && !$past(req_wr) |=> !trap;
	endproperty
	a_reset: assert property (p_reset)
		else $error("status not cleared by reset");
	a_ready: assert property (p_ready)
		else $error("pready low");
	a_err: assert property (p_err)
		else $error("pslverr wrong");
	a_halt: assert property (p_halt)
		else $error("halt request gave no verdict");
	a_halt_src: assert property (p_halt_src)
		else $error("halt without halt request");
	a_trap_src: assert property (p_trap_src)
		else $error("trap without request");
	a_trap_hold: assert property (p_trap_hold)
		else $error("trap dropped");
	a_halt_hold: assert property (p_halt_hold)
		else $error("halt dropped");
	a_trap_clr: assert property (p_trap_clr)
		else $error("trap not cleared");
endmodule
bind privilege_flag_guard privilege_flag_guard_props u_props (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .halted(halted), .trap(trap));
`default_nettype wire

// *** verif/tb_privilege_flag_guard.sv ***
// Testbench: table-driven checks of the privilege flag guard
`timescale 1ns/1ns
`default_nettype none
module tb_privilege_flag_guard;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        halted, trap, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] r;
	logic [63:0] rows [21];
	int          n_fail, n_checks, cyc;
	privilege_flag_guard uut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .halted(halted), .trap(trap));
	// ==========================================================
	// Clock, timeout and tasks
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rst(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask
	// ==========================================================
	// Rows: mode, word, request, flags, result, result mask
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		rows = '{64'h8020_0000_0044_7000, 64'h8220_0000_0044_7000,
			64'hC020_0000_0044_7000, 64'hA020_0000_0054_7000,
			64'h8120_0000_0054_7000, 64'h805D_F000_0046_7000,
			64'h805E_0000_0044_7000, 64'h805E_0010_0046_7000,
			64'hC05E_0010_0064_7000, 64'h8060_0C00_0046_7000,
			64'hC060_0C00_0064_7000, 64'hA080_0080_0056_7000,
			64'hA0C0_00A0_0054_7000, 64'hA0C0_0080_0056_7000,
			64'h1080_0080_0004_7000, 64'h10A0_0080_0006_7000,
			64'h1040_0000_0006_7000, 64'h10E0_0000_0006_7000,
			64'h0040_0000_010C_F000, 64'h0040_0000_0204_F000,
			64'h0060_0400_0005_7000};
		@(posedge clk);
		rst(20);
		apb(1'b0, guard_pkg::ADDR_RESULT, 32'h0);
		chk("reset", 32'h0000_0010, {rd[29:0], halted, trap});
		foreach (rows[i]) begin
			r = rows[i];
			rst(1);
			apb(1'b1, guard_pkg::ADDR_CTRL, {28'h0, r[63:60]});
			apb(1'b1, guard_pkg::ADDR_WORD, {r[59:56], 28'h0});
			apb(1'b1, guard_pkg::ADDR_REQ, r[55:24]);
			apb(1'b0, guard_pkg::ADDR_FLAGS, 32'h0);
			chk("flags", {29'h0, r[22:20]}, {29'h0, rd[30:28]});
			apb(1'b0, guard_pkg::ADDR_RESULT, 32'h0);
			chk("result", {28'h0, r[19:16] & r[15:12]},
				{28'h0, rd[3:0] & r[15:12]});
			chk("pins", {30'h0, r[17:16]}, {30'h0, trap, halted});
			$display("row %0d done", i);
		end
		// ======================================================
		// Hand-written cases
		rst(1);
		apb(1'b1, guard_pkg::ADDR_CTRL, 32'h8);
		apb(1'b1, guard_pkg::ADDR_CTRL, 32'h0);
		apb(1'b0, guard_pkg::ADDR_FLAGS, 32'h0);
		chk("user lock", 32'h1, {31'h0, rd[30]});
		apb(1'b0, 8'h1C, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("lock and unmapped done");
		rst(1);
		apb(1'b1, guard_pkg::ADDR_REQ, 32'h6004_0000);
		@(negedge clk);
		chk("halt", 32'h1, {31'h0, halted});
		apb(1'b1, guard_pkg::ADDR_CTRL, 32'h10);
		chk("halt clr", 32'h0, {31'h0, halted});
		apb(1'b1, guard_pkg::ADDR_CTRL, 32'h1);
		apb(1'b1, guard_pkg::ADDR_REQ, 32'h4000_0000);
		apb(1'b1, guard_pkg::ADDR_REQ, 32'h5E00_0000);
		chk("trap sticky", 32'h1, {31'h0, trap});
		apb(1'b1, guard_pkg::ADDR_CTRL, 32'h21);
		chk("trap clr", 32'h0, {31'h0, trap});
		$display("halt and trap done");
		stop_test();
	end
endmodule
`default_nettype wire
